/* hw/plb_top.sv */
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "plb_map.svh"
module plb_top (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire plb_pkg::plb_bus_t PWDATA,
  output plb_pkg::plb_bus_t PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HIGH_SIDE_OUTPUT,
  input wire logic LOW_SIDE_OUTPUT,
  input wire logic BLANK_SIGNAL,
  input wire logic FAULT_IN,
  input wire logic CURLIM_IN,
  output logic FAULT_OUT,
  output logic CURLIM_OUT,
  output logic BLANK_ACTIVE
);
  import plb_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic hs;
  logic ls;
  logic bsig;
  logic flt;
  logic cl;
  plb_sync u_hs (.clk(MCLK), .rst(RST), .din(HIGH_SIDE_OUTPUT), .dout(hs));
  plb_sync u_ls (.clk(MCLK), .rst(RST), .din(LOW_SIDE_OUTPUT), .dout(ls));
  plb_sync u_bs (.clk(MCLK), .rst(RST), .din(BLANK_SIGNAL), .dout(bsig));
  plb_sync u_fl (.clk(MCLK), .rst(RST), .din(FAULT_IN), .dout(flt));
  plb_sync u_cl (.clk(MCLK), .rst(RST), .din(CURLIM_IN), .dout(cl));

  // ------------------------------------------------------------
  // apb register file
  // ------------------------------------------------------------
  plb_word_t blanking_control;
  plb_word_t blank_delay;
  wire setup = PSEL && !PENABLE;
  wire access_done = PSEL && PENABLE && PREADY;
  wire hit_ctrl = PADDR == `PLB_CTRL_ADDR;
  wire hit_delay = PADDR == `PLB_DELAY_ADDR;
  wire hit_stat = PADDR == `PLB_STAT_ADDR;
  wire hit_any = hit_ctrl || hit_delay || hit_stat;
  wire wr_ctrl = access_done && PWRITE && hit_ctrl;
  wire wr_delay = access_done && PWRITE && hit_delay;
  plb_word_t stat_word;
  plb_word_t rd_word;
  // picked in setup so that pready and prdata leave their flops together
  assign rd_word = hit_ctrl ? blanking_control : hit_delay ? blank_delay : hit_stat ? stat_word : 16'h0000;

  // no wait state: setup, then a single access cycle with pready high
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !hit_any;
      PRDATA <= (setup && !PWRITE) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      blanking_control <= `PLB_CTRL_RST;
      blank_delay <= `PLB_DELAY_RST;
    end else begin
      if (wr_ctrl) begin
        blanking_control <= PWDATA[15:0] & `PLB_CTRL_MASK;
      end
      if (wr_delay) begin
        blank_delay <= PWDATA[15:0];
      end
    end
  end

  // ------------------------------------------------------------
  // edge detection and triggers
  // ------------------------------------------------------------
  logic hs_d;
  logic ls_d;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      hs_d <= 1'b0;
      ls_d <= 1'b0;
    end else begin
      hs_d <= hs;
      ls_d <= ls;
    end
  end
  wire hs_rise = hs && !hs_d;
  wire hs_fall = !hs && hs_d;
  wire ls_rise = ls && !ls_d;
  wire ls_fall = !ls && ls_d;
  wire trig_h = (hs_rise && blanking_control[`PLB_HRISE_BIT]) || (hs_fall && blanking_control[`PLB_HFALL_BIT]);
  wire trig_l = (ls_rise && blanking_control[`PLB_LRISE_BIT]) || (ls_fall && blanking_control[`PLB_LFALL_BIT]);
  wire trig = trig_h || trig_l;

  // ------------------------------------------------------------
  // leading-edge blanking counter
  // ------------------------------------------------------------
  plb_state_t state;
  plb_state_t next_state;
  plb_word_t count;
  plb_word_t next_count;
  // a zero delay gives no blanking, a fresh edge restarts the window
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      PLB_IDLE: begin
        if (trig && blank_delay != `PLB_DELAY_RST) begin
          next_state = PLB_COUNT;
          next_count = `PLB_CNT_ONE;
        end
      end
      PLB_COUNT: begin
        if (trig) begin
          next_count = `PLB_CNT_ONE;
        end else if (count >= blank_delay) begin
          next_state = PLB_IDLE;
          next_count = `PLB_DELAY_RST;
        end else begin
          next_count = count + `PLB_CNT_ONE;
        end
      end
      default: begin
        next_state = PLB_IDLE;
        next_count = `PLB_DELAY_RST;
      end
    endcase
  end
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state <= PLB_IDLE;
      count <= `PLB_DELAY_RST;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end
  wire leb_on = state == PLB_COUNT;

  // ------------------------------------------------------------
  // state blanking and masking
  // ------------------------------------------------------------
  wire st_out = (hs && blanking_control[`PLB_HSH_BIT]) || (!hs && blanking_control[`PLB_HSL_BIT])
    || (ls && blanking_control[`PLB_LSH_BIT]) || (!ls && blanking_control[`PLB_LSL_BIT]);
  wire st_sel = (bsig && blanking_control[`PLB_SELH_BIT]) || (!bsig && blanking_control[`PLB_SELL_BIT]);
  wire st_blank = st_out || st_sel;
  wire mask_f = st_blank || (leb_on && blanking_control[`PLB_FLT_BIT]);
  wire mask_c = st_blank || (leb_on && blanking_control[`PLB_CL_BIT]);
  assign stat_word = {13'h0000, st_blank, leb_on, ls};

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      FAULT_OUT <= 1'b0;
      CURLIM_OUT <= 1'b0;
      BLANK_ACTIVE <= 1'b0;
    end else begin
      FAULT_OUT <= flt && !mask_f;
      CURLIM_OUT <= cl && !mask_c;
      BLANK_ACTIVE <= leb_on || st_blank;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // checks look at the synchronised levels, not at the raw pins
  hrise_trigger_a: assert property (hs_rise && blanking_control[`PLB_HRISE_BIT] && blank_delay != 16'h0000
    |=> leb_on) else $error("high rise did not start blanking");
  lfall_trigger_a: assert property (ls_fall && blanking_control[`PLB_LFALL_BIT] && blank_delay != 16'h0000
    |=> leb_on && count == 16'h0001) else $error("low fall did not start blanking");
  no_trig_a: assert property (!leb_on && !trig |=> !leb_on) else $error("blanking started without edge");
  fault_pass_a: assert property (!mask_f && flt |=> FAULT_OUT) else $error("unmasked fault dropped");
  fault_mask_a: assert property (leb_on && blanking_control[`PLB_FLT_BIT] |=> !FAULT_OUT)
    else $error("fault passed during blanking");
  state_mask_a: assert property (st_out |=> !CURLIM_OUT && !FAULT_OUT) else $error("state blank leaked");
  sel_mask_a: assert property (st_sel |=> !CURLIM_OUT) else $error("select blank leaked");
  window_end_a: assert property (leb_on && !trig && count >= blank_delay |=> !leb_on)
    else $error("blanking overran delay");
  apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY) else $error("apb answer timing");
  hfall_trigger_a: assert property (hs_fall && blanking_control[`PLB_HFALL_BIT] && blank_delay != 16'h0000
    |=> leb_on && count == 16'h0001) else $error("high fall did not start blanking");
  lrise_trigger_a: assert property (ls_rise && blanking_control[`PLB_LRISE_BIT] && blank_delay != 16'h0000
    |=> leb_on && count == 16'h0001) else $error("low rise did not start blanking");
  curlim_mask_a: assert property (leb_on && blanking_control[`PLB_CL_BIT] |=> !CURLIM_OUT)
    else $error("current limit passed during blanking");
  curlim_pass_a: assert property (!mask_c && cl |=> CURLIM_OUT)
    else $error("unmasked current limit dropped");
  fault_gate_a: assert property (!st_blank && !blanking_control[`PLB_FLT_BIT] && flt |=> FAULT_OUT)
    else $error("fault blanked while its blanking is off");
  hs_low_mask_a: assert property (!hs && blanking_control[`PLB_HSL_BIT] |=> !FAULT_OUT && !CURLIM_OUT)
    else $error("high side low blank leaked");
  sel_low_a: assert property (!bsig && blanking_control[`PLB_SELL_BIT] |=> !FAULT_OUT && !CURLIM_OUT)
    else $error("select low blank leaked");
  zero_delay_a: assert property (!leb_on && blank_delay == 16'h0000 |=> !leb_on)
    else $error("blanking started with zero delay");
  unmapped_err_a: assert property (PSEL && !PENABLE && !hit_any |=> PREADY && PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped access not refused");
  ctrl_write_a: assert property (wr_ctrl |=> blanking_control == ($past(PWDATA[15:0]) & `PLB_CTRL_MASK))
    else $error("control write lost");
  leb_cov: cover property (trig ##1 leb_on [*3] ##1 !leb_on);
  sel_cov: cover property (st_sel && flt);
  write_cov: cover property (wr_ctrl);
  lfall_cov: cover property (ls_fall && blanking_control[`PLB_LFALL_BIT] ##1 leb_on);
  slverr_cov: cover property (PREADY && PSLVERR);
endmodule

/* hw/plb_map.svh */
`ifndef PLB_MAP_SVH
`define PLB_MAP_SVH
// register byte addresses
`define PLB_CTRL_ADDR 12'h000
`define PLB_DELAY_ADDR 12'h004
`define PLB_STAT_ADDR 12'h008
// control field positions
`define PLB_HRISE_BIT 15
`define PLB_HFALL_BIT 14
`define PLB_LRISE_BIT 13
`define PLB_LFALL_BIT 12
`define PLB_FLT_BIT 11
`define PLB_CL_BIT 10
`define PLB_SELH_BIT 5
`define PLB_SELL_BIT 4
`define PLB_HSH_BIT 3
`define PLB_HSL_BIT 2
`define PLB_LSH_BIT 1
`define PLB_LSL_BIT 0
// writable bits of the control register
`define PLB_CTRL_MASK 16'hfc3f
`define PLB_CTRL_RST 16'h0000
`define PLB_DELAY_RST 16'h0000
`define PLB_CNT_ONE 16'h0001
`endif

/* hw/plb_pkg.sv */
package plb_pkg;
  typedef logic [15:0] plb_word_t;
  typedef logic [31:0] plb_bus_t;
  typedef enum logic {PLB_IDLE, PLB_COUNT} plb_state_t;
endpackage

/* hw/plb_sync.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// three-stage input synchroniser with agreement filter
// ------------------------------------------------------------
module plb_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  import plb_pkg::*;
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      // a change counts only once stages two and three agree
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule

/* test/plb_pwm_src.sv */
`timescale 1ns/1ns
// ----------------------------------------
// pwm drivers and fault sources
// ----------------------------------------
module plb_pwm_src (
  input wire logic clk,
  input wire logic [4:0] cmd,
  output logic [4:0] pins
);
  // levels move only on the pwm clock edge, never mid-cycle
  always @(posedge clk) begin
    pins <= cmd;
  end
endmodule

/* test/pwm_leading_edge_blanking_test.sv */
`timescale 1ns/1ns
`include "plb_map.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module pwm_leading_edge_blanking_test;
  import plb_pkg::*;
  logic mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  plb_bus_t pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, fault_out, curlim_out, blank_active, err, m;
  // pins: hs, ls, blank signal, fault, current limit
  logic [4:0] cmd = 5'h03, pins, p;
  int err_total = 0, samples_checked = 0, cycles = 0, nf, nc, nb, d;
  logic [31:0] seed = 32'h7e2aedf5;
  plb_word_t c;
  plb_pwm_src src_u (.clk(mclk), .cmd(cmd), .pins(pins));
  plb_top dut_u (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HIGH_SIDE_OUTPUT(pins[4]), .LOW_SIDE_OUTPUT(pins[3]), .BLANK_SIGNAL(pins[2]),
    .FAULT_IN(pins[1]), .CURLIM_IN(pins[0]), .FAULT_OUT(fault_out), .CURLIM_OUT(curlim_out),
    .BLANK_ACTIVE(blank_active));
  initial begin
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task stop_test;
    $display("checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end
  task apb(input logic w, input logic [11:0] a, input plb_bus_t wd);
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // counts masked cycles; window is long enough to cover sync latency
  task count_low;
    nf = 0;
    nc = 0;
    nb = 0;
    repeat (30) begin
      @(posedge mclk);
      nf += (fault_out === 1'h0);
      nc += (curlim_out === 1'h0);
      nb += (blank_active === 1'h1);
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'h0;
    apb(1'h0, `PLB_CTRL_ADDR, 32'h0);
    `CHK("ctrl reset", 32'h0, rd)
    apb(1'h1, `PLB_CTRL_ADDR, 32'hffffffff);
    apb(1'h0, `PLB_CTRL_ADDR, 32'h0);
    `CHK("ctrl mask", {16'h0, `PLB_CTRL_MASK}, rd)
    apb(1'h0, 12'h0f0, 32'h0);
    `CHK("unmapped", 1'h1, err)
    `CHK("unmapped data", 32'h0, rd)
    $display("register test done");
    for (int b = 0; b < 6; b++) begin
      for (int k = 0; k < 4; k++) begin
        seed = xs(seed);
        c = 16'h1 << b;
        apb(1'h1, `PLB_CTRL_ADDR, {16'h0, c});
        cmd <= seed[4:0];
        repeat (10) @(posedge mclk);
        m = (c[3] & seed[4]) | (c[2] & !seed[4]) | (c[1] & seed[3]) | (c[0] & !seed[3]);
        m = m | (c[5] & seed[2]) | (c[4] & !seed[2]);
        `CHK("fault state", seed[1] & !m, fault_out)
        `CHK("curlim state", seed[0] & !m, curlim_out)
        apb(1'h0, `PLB_STAT_ADDR, 32'h0);
        `CHK("status", {29'h0, m, 1'h0, seed[3]}, rd)
      end
    end
    $display("state blanking test done");
    for (int tr = 0; tr < 4; tr++) begin
      for (int ek = 0; ek < 4; ek++) begin
        seed = xs(seed);
        d = seed[2:0] + 1;
        p = 5'h10 >> ek[1];
        apb(1'h1, `PLB_CTRL_ADDR, 32'h0);
        apb(1'h1, `PLB_DELAY_ADDR, d);
        apb(1'h0, `PLB_DELAY_ADDR, 32'h0);
        `CHK("delay", d, rd)
        cmd <= ek[0] ? (p | 5'h03) : 5'h03;
        repeat (8) @(posedge mclk);
        c = (16'h8000 >> tr) | (seed[3] ? 16'h0800 : 16'h0400);
        apb(1'h1, `PLB_CTRL_ADDR, {16'h0, c});
        cmd <= cmd ^ p;
        count_low();
        `CHK("edge blank", (tr == ek) ? d : 0, nb)
        `CHK("fault edge", (tr == ek && seed[3]) ? d : 0, nf)
        `CHK("curlim edge", (tr == ek && !seed[3]) ? d : 0, nc)
      end
    end
    $display("edge blanking test done");
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    `CHK("reset outputs", 3'h0, {fault_out, curlim_out, blank_active})
    rst <= 1'h0;
    apb(1'h0, `PLB_CTRL_ADDR, 32'h0);
    `CHK("ctrl after reset", 32'h0, rd)
    apb(1'h0, `PLB_DELAY_ADDR, 32'h0);
    `CHK("delay after reset", 32'h0, rd)
    $display("reset test done");
    stop_test();
  end
endmodule
